/* File: design/swcfg_pkg.sv */
// register indices, field positions and reset values of the switch configuration bank
package swcfg_pkg;
	// register word indices; byte address is four times the index
	localparam logic [7:0] IDX_DIR_UPPER = 8'h0D;
	localparam logic [7:0] IDX_DBG_T0 = 8'h10;
	localparam logic [7:0] IDX_DBG_T1 = 8'h11;
	localparam logic [7:0] IDX_DBG_ORIGIN = 8'h1F;
	localparam logic [7:0] IDX_LINK_STAT = 8'h20;
	localparam logic [7:0] IDX_PROCESSOR_LINK_STAT = 8'h40;
	localparam logic [7:0] IDX_LINK_CFG = 8'h80;
	localparam logic [7:0] IDX_STATIC = 8'hA0;
	// debug pin configuration and origin fields
	localparam int DBG_REQ_EN = 1;
	localparam int DBG_DRIVE_EN = 0;
	localparam int ORG_EXT = 4;
	localparam int ORG_P1 = 1;
	localparam int ORG_P0 = 0;
	// link and processor-link status fields
	localparam int ST_SRC_LSB = 24;
	localparam int ST_DEST_LSB = 16;
	localparam int ST_DIR_LSB = 8;
	localparam int ST_NET_LSB = 4;
	localparam int ST_JUNK = 2;
	localparam int ST_DST_BUSY = 1;
	localparam int ST_SRC_BUSY = 0;
	// link setup fields
	localparam int CFG_EN = 31;
	localparam int CFG_WIDE = 30;
	localparam int CFG_ERR = 27;
	localparam int CFG_CR_ISSUED = 26;
	localparam int CFG_CR_HAVE = 25;
	localparam int CFG_CREDIT_REQUEST_TOKEN = 24;
	localparam int CFG_RXRST = 23;
	localparam int CFG_SYM_LSB = 11;
	localparam int CFG_TOK_LSB = 0;
	// static forwarding fields
	localparam int STC_EN = 31;
	localparam int STC_CE_LSB = 0;
	// reset values
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	localparam logic [11:0] RST_GAP_CNT = 12'h000;
	typedef enum logic [1:0] {
		SRC_SERIAL = 2'h0,
		SRC_PROC = 2'h1,
		SRC_CTRL = 2'h2,
		SRC_UNDEF = 2'h3
	} source_target_type_t;
endpackage : swcfg_pkg

/* File: design/switch_link_routing_config_regs.sv */
// configuration and status register bank of the message switch, with debug pin and link pacing logic
`timescale 1ns/100ps
module switch_link_routing_config_regs (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// apb slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [9:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// routing lookup
	input wire logic [15:0] node_id_i,
	input wire logic [15:0] dest_node_id_i,
	output logic [3:0] route_dir_o,
	output logic route_hit_o,
	// debug pin (open drain) and tiles
	input wire logic debug_pin_i,
	output logic debug_pin_o,
	output logic debug_pin_oe_n_o,
	input wire logic [1:0] core_halted_flag_i,
	output logic [1:0] debug_req_o,
	// link status from the switch
	input wire logic [7:0][1:0] link_src_type_i,
	input wire logic [7:0][7:0] link_dest_i,
	input wire logic [7:0] link_junk_i,
	input wire logic [7:0] link_dst_busy_i,
	input wire logic [7:0] link_src_busy_i,
	input wire logic [7:0][1:0] processor_link_src_type_i,
	input wire logic [7:0][7:0] processor_link_dest_i,
	input wire logic [7:0] processor_link_junk_i,
	input wire logic [7:0] processor_link_dst_busy_i,
	input wire logic [7:0] processor_link_src_busy_i,
	output logic [7:0][3:0] link_dir_o,
	output logic [7:0][1:0] link_net_o,
	output logic [7:0][1:0] processor_link_net_o,
	// external link setup and transmit pacing
	input wire logic [7:0] rx_err_i,
	input wire logic [7:0] credit_issued_i,
	input wire logic [7:0] credit_have_i,
	input wire logic [7:0] sym_sent_i,
	input wire logic [7:0] tok_sent_i,
	output logic [7:0] link_en_o,
	output logic [7:0] link_wide_o,
	output logic [7:0] credit_request_token_o,
	output logic [7:0] rx_reset_o,
	output logic [7:0] tx_ready_o,
	// static forwarding, indexed by link A..H
	output logic [7:0] static_en_o,
	output logic [7:0][4:0] static_chanend_o
);
	logic rst_meta_ff, rst_n;
	logic dbg_meta_ff, dbg_pin_n_ff;
	logic pready_ff, pslverr_ff;
	logic [31:0] prdata_ff;
	logic [7:0][3:0] dir_upper_ff;
	logic [1:0][1:0] dbg_cfg_ff;
	logic [2:0] origin_ff;
	logic glob_ff, drive_ff, oe_n_ff;
	logic [1:0] drive_src_ff, drive_req;
	logic [1:0] dreq_ff;
	logic [3:0] route_dir_ff;
	logic route_hit_ff;
	logic [7:0][3:0] link_dir_ff;
	logic [7:0][1:0] link_net_ff, processor_link_net_ff;
	logic [7:0] link_en_ff, link_wide_ff, link_err_ff, credit_request_token_ff, rxrst_ff;
	logic [7:0][10:0] sym_gap_ff, tok_gap_ff;
	logic [7:0] stat_en_ff;
	logic [7:0][4:0] stat_ce_ff;
	logic [7:0][11:0] tx_cnt_ff, nxt_tx_cnt;
	logic [7:0] tx_ready_ff;
	logic [7:0] idx;
	logic [2:0] sub;
	logic acc, wr;
	logic [31:0] nxt_prdata;
	logic nxt_slverr;
	logic glob_now;
	logic [7:0] route_diff;
	logic [2:0] route_dim;

	function automatic logic [31:0] stat_word(input logic [1:0] t, input logic [7:0] d, input logic [1:0] n,
		input logic j, input logic db, input logic sb);
		stat_word = swcfg_pkg::RST_WORD;
		stat_word[swcfg_pkg::ST_SRC_LSB+:2] = t;
		stat_word[swcfg_pkg::ST_DEST_LSB+:8] = d;
		stat_word[swcfg_pkg::ST_NET_LSB+:2] = n;
		stat_word[swcfg_pkg::ST_JUNK] = j;
		stat_word[swcfg_pkg::ST_DST_BUSY] = db;
		stat_word[swcfg_pkg::ST_SRC_BUSY] = sb;
	endfunction : stat_word

	// register index k drives link C,D,A,B,G,H,E,F: flipping bit 1 of k gives the link letter
	function automatic logic [2:0] static_link(input logic [2:0] k);
		static_link = k ^ 3'h2;
	endfunction : static_link

	function automatic logic group_hit(input logic [7:0] i, input logic [7:0] base);
		group_hit = (i[7:3] == base[7:3]);
	endfunction : group_hit

	// reset release and pin synchronisers
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_meta_ff <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_n <= rst_meta_ff;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			// reset to the idle (high) pin level so no false debug event follows reset
			dbg_meta_ff <= 1'b1;
			dbg_pin_n_ff <= 1'b1;
		end else begin
			dbg_meta_ff <= debug_pin_i;
			dbg_pin_n_ff <= dbg_meta_ff;
		end
	end

	// apb: one wait state, write lands at the edge that samples pready
	assign idx = paddr_i[9:2];
	assign sub = idx[2:0];
	assign acc = psel_i & penable_i & ~pready_ff;
	assign wr = psel_i & penable_i & pready_ff & pwrite_i & ~pslverr_ff;

	always_comb begin
		nxt_prdata = swcfg_pkg::RST_WORD;
		nxt_slverr = 1'b0;
		if (idx == swcfg_pkg::IDX_DIR_UPPER) begin
			nxt_prdata = dir_upper_ff;
		end else if (idx == swcfg_pkg::IDX_DBG_T0 || idx == swcfg_pkg::IDX_DBG_T1) begin
			nxt_prdata[1:0] = dbg_cfg_ff[idx[0]];
		end else if (idx == swcfg_pkg::IDX_DBG_ORIGIN) begin
			nxt_prdata[swcfg_pkg::ORG_EXT] = origin_ff[2];
			nxt_prdata[swcfg_pkg::ORG_P1] = origin_ff[1];
			nxt_prdata[swcfg_pkg::ORG_P0] = origin_ff[0];
		end else if (group_hit(idx, swcfg_pkg::IDX_LINK_STAT)) begin
			nxt_prdata = stat_word(link_src_type_i[sub], link_dest_i[sub], link_net_ff[sub],
				link_junk_i[sub], link_dst_busy_i[sub], link_src_busy_i[sub]);
			nxt_prdata[swcfg_pkg::ST_DIR_LSB+:4] = link_dir_ff[sub];
		end else if (group_hit(idx, swcfg_pkg::IDX_PROCESSOR_LINK_STAT)) begin
			nxt_prdata = stat_word(processor_link_src_type_i[sub], processor_link_dest_i[sub], processor_link_net_ff[sub],
				processor_link_junk_i[sub], processor_link_dst_busy_i[sub], processor_link_src_busy_i[sub]);
		end else if (group_hit(idx, swcfg_pkg::IDX_LINK_CFG)) begin
			nxt_prdata[swcfg_pkg::CFG_EN] = link_en_ff[sub];
			nxt_prdata[swcfg_pkg::CFG_WIDE] = link_wide_ff[sub];
			nxt_prdata[swcfg_pkg::CFG_ERR] = link_err_ff[sub];
			nxt_prdata[swcfg_pkg::CFG_CR_ISSUED] = credit_issued_i[sub];
			nxt_prdata[swcfg_pkg::CFG_CR_HAVE] = credit_have_i[sub];
			nxt_prdata[swcfg_pkg::CFG_SYM_LSB+:11] = sym_gap_ff[sub];
			nxt_prdata[swcfg_pkg::CFG_TOK_LSB+:11] = tok_gap_ff[sub];
		end else if (group_hit(idx, swcfg_pkg::IDX_STATIC)) begin
			nxt_prdata[swcfg_pkg::STC_EN] = stat_en_ff[static_link(sub)];
			nxt_prdata[swcfg_pkg::STC_CE_LSB+:5] = stat_ce_ff[static_link(sub)];
		end else begin
			nxt_slverr = 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= swcfg_pkg::RST_WORD;
		end else begin
			pready_ff <= acc;
			pslverr_ff <= acc & nxt_slverr;
			if (acc && !pwrite_i) begin
				prdata_ff <= nxt_prdata;
			end
		end
	end

	// direction table and route lookup
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			dir_upper_ff <= swcfg_pkg::RST_WORD;
		end else if (wr && idx == swcfg_pkg::IDX_DIR_UPPER) begin
			dir_upper_ff <= pwdata_i;
		end
	end

	always_comb begin
		route_diff = dest_node_id_i[15:8] ^ node_id_i[15:8];
		route_dim = 3'h0;
		for (int b = 0; b < 8; b++) begin
			if (route_diff[b]) begin
				route_dim = 3'(b);
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			route_dir_ff <= 4'h0;
			route_hit_ff <= 1'b0;
		end else begin
			route_dir_ff <= dir_upper_ff[route_dim];
			route_hit_ff <= |route_diff;
		end
	end

	// debug pin: the shared signal is the wired-or of the pin and enabled halted cores
	assign glob_now = ~dbg_pin_n_ff | drive_ff;
	assign drive_req = core_halted_flag_i & {dbg_cfg_ff[1][swcfg_pkg::DBG_DRIVE_EN],
		dbg_cfg_ff[0][swcfg_pkg::DBG_DRIVE_EN]};

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			dbg_cfg_ff <= 4'h0;
		end else if (wr && (idx == swcfg_pkg::IDX_DBG_T0 || idx == swcfg_pkg::IDX_DBG_T1)) begin
			dbg_cfg_ff[idx[0]] <= pwdata_i[1:0];
		end
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			drive_ff <= 1'b0;
			oe_n_ff <= 1'b1;
			drive_src_ff <= 2'h0;
			glob_ff <= 1'b0;
			dreq_ff <= 2'h0;
		end else begin
			drive_ff <= |drive_req;
			oe_n_ff <= ~(|drive_req);
			// kept per core so the origin matches the drive that raised the event
			drive_src_ff <= drive_req;
			glob_ff <= glob_now;
			dreq_ff <= {2{glob_now}} & {dbg_cfg_ff[1][swcfg_pkg::DBG_REQ_EN],
				dbg_cfg_ff[0][swcfg_pkg::DBG_REQ_EN]};
		end
	end

	// a new event overrides a software write in the same cycle
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			origin_ff <= 3'h0;
		end else if (glob_now && !glob_ff) begin
			origin_ff <= {~dbg_pin_n_ff, drive_src_ff};
		end else if (wr && idx == swcfg_pkg::IDX_DBG_ORIGIN) begin
			origin_ff <= {pwdata_i[swcfg_pkg::ORG_EXT], pwdata_i[swcfg_pkg::ORG_P1], pwdata_i[swcfg_pkg::ORG_P0]};
		end
	end

	// link direction and network numbers
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			link_dir_ff <= swcfg_pkg::RST_WORD;
			link_net_ff <= 16'h0000;
			processor_link_net_ff <= 16'h0000;
		end else if (wr && group_hit(idx, swcfg_pkg::IDX_LINK_STAT)) begin
			link_dir_ff[sub] <= pwdata_i[swcfg_pkg::ST_DIR_LSB+:4];
			link_net_ff[sub] <= pwdata_i[swcfg_pkg::ST_NET_LSB+:2];
		end else if (wr && group_hit(idx, swcfg_pkg::IDX_PROCESSOR_LINK_STAT)) begin
			processor_link_net_ff[sub] <= pwdata_i[swcfg_pkg::ST_NET_LSB+:2];
		end
	end

	// link setup; the action bits are one-cycle strobes and never read back
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			link_en_ff <= 8'h00;
			link_wide_ff <= 8'h00;
			sym_gap_ff <= 88'h0;
			tok_gap_ff <= 88'h0;
			credit_request_token_ff <= 8'h00;
			rxrst_ff <= 8'h00;
		end else begin
			credit_request_token_ff <= 8'h00;
			rxrst_ff <= 8'h00;
			if (wr && group_hit(idx, swcfg_pkg::IDX_LINK_CFG)) begin
				link_en_ff[sub] <= pwdata_i[swcfg_pkg::CFG_EN];
				link_wide_ff[sub] <= pwdata_i[swcfg_pkg::CFG_WIDE];
				sym_gap_ff[sub] <= pwdata_i[swcfg_pkg::CFG_SYM_LSB+:11];
				tok_gap_ff[sub] <= pwdata_i[swcfg_pkg::CFG_TOK_LSB+:11];
				credit_request_token_ff[sub] <= pwdata_i[swcfg_pkg::CFG_CREDIT_REQUEST_TOKEN];
				rxrst_ff[sub] <= pwdata_i[swcfg_pkg::CFG_RXRST];
			end
		end
	end

	// error is sticky until the receiver is reset; a fresh error wins over the reset
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			link_err_ff <= 8'h00;
		end else begin
			link_err_ff <= rx_err_i | (link_err_ff & ~rxrst_ff);
		end
	end

	// pacing: after a send the counter holds gap+1 idle clocks before ready returns
	always_comb begin
		for (int k = 0; k < 8; k++) begin
			if (tok_sent_i[k]) begin
				nxt_tx_cnt[k] = {1'b0, tok_gap_ff[k]} + 12'h001;
			end else if (sym_sent_i[k]) begin
				nxt_tx_cnt[k] = {1'b0, sym_gap_ff[k]} + 12'h001;
			end else if (tx_cnt_ff[k] != swcfg_pkg::RST_GAP_CNT) begin
				nxt_tx_cnt[k] = tx_cnt_ff[k] - 12'h001;
			end else begin
				nxt_tx_cnt[k] = tx_cnt_ff[k];
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			tx_cnt_ff <= 96'h0;
			tx_ready_ff <= 8'h00;
		end else begin
			tx_cnt_ff <= nxt_tx_cnt;
			for (int k = 0; k < 8; k++) begin
				tx_ready_ff[k] <= (nxt_tx_cnt[k] == swcfg_pkg::RST_GAP_CNT) & link_en_ff[k] & credit_have_i[k];
			end
		end
	end

	// static forwarding, stored by link letter
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			stat_en_ff <= 8'h00;
			stat_ce_ff <= 40'h0;
		end else if (wr && group_hit(idx, swcfg_pkg::IDX_STATIC)) begin
			stat_en_ff[static_link(sub)] <= pwdata_i[swcfg_pkg::STC_EN];
			stat_ce_ff[static_link(sub)] <= pwdata_i[swcfg_pkg::STC_CE_LSB+:5];
		end
	end

	assign prdata_o = prdata_ff;
	assign pready_o = pready_ff;
	assign pslverr_o = pslverr_ff;
	assign route_dir_o = route_dir_ff;
	assign route_hit_o = route_hit_ff;
	assign debug_pin_o = 1'b0;
	assign debug_pin_oe_n_o = oe_n_ff;
	assign debug_req_o = dreq_ff;
	assign link_dir_o = link_dir_ff;
	assign link_net_o = link_net_ff;
	assign processor_link_net_o = processor_link_net_ff;
	assign link_en_o = link_en_ff;
	assign link_wide_o = link_wide_ff;
	assign credit_request_token_o = credit_request_token_ff;
	assign rx_reset_o = rxrst_ff;
	assign tx_ready_o = tx_ready_ff;
	assign static_en_o = stat_en_ff;
	assign static_chanend_o = stat_ce_ff;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n);

	property p_dir_wr;
		wr && idx == swcfg_pkg::IDX_DIR_UPPER |=> dir_upper_ff == $past(pwdata_i);
	endproperty
	a_dir_wr: assert property (p_dir_wr) else $error("direction table write lost");

	property p_route;
		##1 route_hit_o == $past(|(dest_node_id_i[15:8] ^ node_id_i[15:8]));
	endproperty
	a_route: assert property (p_route) else $error("route hit wrong");

	property p_dreq;
		glob_now && dbg_cfg_ff[1][swcfg_pkg::DBG_REQ_EN] |=> debug_req_o[1];
	endproperty
	a_dreq: assert property (p_dreq) else $error("debug request missing");

	property p_drive;
		core_halted_flag_i[1] && dbg_cfg_ff[1][swcfg_pkg::DBG_DRIVE_EN] |=> !debug_pin_oe_n_o;
	endproperty
	a_drive: assert property (p_drive) else $error("halted core not driving debug pin");

	property p_credit_request_token;
		wr && group_hit(idx, swcfg_pkg::IDX_LINK_CFG) && pwdata_i[swcfg_pkg::CFG_CREDIT_REQUEST_TOKEN]
			|=> credit_request_token_o[$past(sub)] ##1 credit_request_token_o == 8'h00;
	endproperty
	a_credit_request_token: assert property (p_credit_request_token) else $error("greeting strobe wrong");

	property p_rxrst;
		wr && group_hit(idx, swcfg_pkg::IDX_LINK_CFG) && pwdata_i[swcfg_pkg::CFG_RXRST] |=> rx_reset_o != 8'h00;
	endproperty
	a_rxrst: assert property (p_rxrst) else $error("receiver reset strobe missing");

	property p_err;
		rx_err_i[0] |=> link_err_ff[0];
	endproperty
	a_err: assert property (p_err) else $error("error flag lost");

	property p_sym_gap;
		sym_sent_i[0] && !tok_sent_i[0] && sym_gap_ff[0] == 11'h003 |=> !tx_ready_o[0] [*4];
	endproperty
	a_sym_gap: assert property (p_sym_gap) else $error("symbol gap too short");

	property p_static;
		wr && idx == swcfg_pkg::IDX_STATIC |=> static_en_o[2] == $past(pwdata_i[swcfg_pkg::STC_EN]);
	endproperty
	a_static: assert property (p_static) else $error("static register order wrong");

	property p_unmapped;
		acc && nxt_slverr |=> pslverr_o && pready_o;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
endmodule : switch_link_routing_config_regs

/* File: test/far_link_peer.sv */
// far end of external link 0: grants credit, sends when allowed, measures idle gaps
`timescale 1ns/100ps
module far_link_peer (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// bench control
	input wire logic grant_i,
	input wire logic go_i,
	input wire logic tok_mode_i,
	// link side
	input wire logic tx_ready_i,
	input wire logic credit_request_token_i,
	output logic credit_have_o,
	output logic credit_issued_o,
	output logic sym_o,
	output logic tok_o,
	output logic [11:0] low_run_o
);
	logic dropped_ff;
	logic [11:0] run_ff;
	// a greeting withdraws credit until the bench grants it afresh
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			dropped_ff <= 1'b0;
		end else if (credit_request_token_i) begin
			dropped_ff <= 1'b1;
		end else if (!grant_i) begin
			dropped_ff <= 1'b0;
		end
	end
	assign credit_have_o = grant_i & ~dropped_ff;
	assign credit_issued_o = grant_i;
	// never sends without ready, which carries the credit
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sym_o <= 1'b0;
			tok_o <= 1'b0;
		end else begin
			sym_o <= go_i & tx_ready_i & ~(sym_o | tok_o) & ~tok_mode_i;
			tok_o <= go_i & tx_ready_i & ~(sym_o | tok_o) & tok_mode_i;
		end
	end
	// length of the last stretch of not-ready after a send
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			run_ff <= 12'h000;
			low_run_o <= 12'h000;
		end else if (sym_o | tok_o) begin
			run_ff <= 12'h000;
		end else if (!tx_ready_i) begin
			run_ff <= run_ff + 12'h001;
		end else if (run_ff != 12'h000) begin
			low_run_o <= run_ff;
			run_ff <= 12'h000;
		end
	end
endmodule : far_link_peer

/* File: test/tb_switch_link_routing_config_regs.sv */
// self-checking bench for the switch configuration bank
`timescale 1ns/100ps
module tb_switch_link_routing_config_regs;
	logic clk, rst_n, psel, penable, pwrite, ext_n, grant, go, tok_mode, have, issued, sym, tok;
	logic [9:0] paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic pready, pslverr, err, route_hit, dbg_pin, dbg_o, dbg_oe_n;
	logic [15:0] node_id, dest_id;
	logic [3:0] route_dir;
	logic [1:0] halted, dbg_req;
	logic [7:0][1:0] lst, pst, link_net, processor_link_net;
	logic [7:0][7:0] ldst, pdst;
	logic [7:0][3:0] link_dir;
	logic [7:0][4:0] st_ce;
	logic [7:0] ljk, ldb, lsb, pjk, pdb, psb, rx_err, link_en, link_wide, credit_request_token, rx_rst, tx_ready, st_en;
	logic [11:0] low_run;
	int err_count = 0;
	int check_count = 0;
	int credit_request_token_cnt = 0;
	int rxr_cnt = 0;
	assign dbg_pin = dbg_oe_n ? ext_n : (dbg_o & ext_n);
	switch_link_routing_config_regs DUT (.clk_i(clk), .rst_n_i(rst_n), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
		.pslverr_o(pslverr), .node_id_i(node_id), .dest_node_id_i(dest_id), .route_dir_o(route_dir),
		.route_hit_o(route_hit), .debug_pin_i(dbg_pin), .debug_pin_o(dbg_o), .debug_pin_oe_n_o(dbg_oe_n),
		.core_halted_flag_i(halted), .debug_req_o(dbg_req), .link_src_type_i(lst), .link_dest_i(ldst),
		.link_junk_i(ljk), .link_dst_busy_i(ldb), .link_src_busy_i(lsb), .processor_link_src_type_i(pst),
		.processor_link_dest_i(pdst), .processor_link_junk_i(pjk), .processor_link_dst_busy_i(pdb), .processor_link_src_busy_i(psb),
		.link_dir_o(link_dir), .link_net_o(link_net), .processor_link_net_o(processor_link_net), .rx_err_i(rx_err),
		.credit_issued_i({7'h00, issued}), .credit_have_i({7'h00, have}), .sym_sent_i({7'h00, sym}),
		.tok_sent_i({7'h00, tok}), .link_en_o(link_en), .link_wide_o(link_wide), .credit_request_token_o(credit_request_token),
		.rx_reset_o(rx_rst), .tx_ready_o(tx_ready), .static_en_o(st_en), .static_chanend_o(st_ce));
	far_link_peer peer (.clk_i(clk), .rst_n_i(rst_n), .grant_i(grant), .go_i(go), .tok_mode_i(tok_mode),
		.tx_ready_i(tx_ready[0]), .credit_request_token_i(credit_request_token[0]), .credit_have_o(have), .credit_issued_o(issued),
		.sym_o(sym), .tok_o(tok), .low_run_o(low_run));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	always @(posedge clk) begin
		if (credit_request_token[0] === 1'b1) credit_request_token_cnt++;
		if (rx_rst[0] === 1'b1) rxr_cnt++;
	end
	task automatic close_out();
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : close_out
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("BAD t=%0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] wd);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rdat = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			err_count++;
			$display("BAD t=%0t no ready", $time);
			close_out();
		end
	endtask : apb
	task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
		apb(1'b0, idx, 32'h0000_0000);
		chk(rdat, exp);
		chk({31'h0, err}, 32'h0000_0000);
	endtask : rd
	task automatic t_reset();
		logic [7:0] idx [8] = '{8'h0D, 8'h10, 8'h11, 8'h1F, 8'h20, 8'h40, 8'h80, 8'hA0};
		foreach (idx[i]) rd(idx[i], 32'h0000_0000);
		apb(1'b0, 8'h28, 32'h0000_0000);
		chk({err, rdat[30:0]}, 32'h8000_0000);
		apb(1'b1, 8'h88, 32'hFFFF_FFFF);
		chk({31'h0, err}, 32'h0000_0001);
		@(posedge clk);
		chk({24'h0, link_en}, 32'h0000_0000);
		$display("reset and unmapped done");
	endtask : t_reset
	task automatic t_route();
		apb(1'b1, 8'h0D, 32'hFEDC_BA98);
		rd(8'h0D, 32'hFEDC_BA98);
		for (int b = 8; b < 16; b++) begin
			@(posedge clk);
			dest_id <= 16'h0100 | (16'h0001 << b);
			repeat (3) @(posedge clk);
			chk({27'h0, route_hit, route_dir}, 32'h10 | b);
		end
		dest_id <= 16'h00FF;
		repeat (3) @(posedge clk);
		chk({31'h0, route_hit}, 32'h0000_0000);
		$display("routing done");
	endtask : t_route
	task automatic t_status();
		for (int t = 0; t < 4; t++) begin
			@(posedge clk);
			lst[3] <= 2'(t);
			rd(8'h23, {6'h0, 2'(t), 24'h0});
		end
		@(posedge clk);
		lst[3] <= 2'h2;
		ldst[3] <= 8'hA5;
		ljk[3] <= 1'b1;
		lsb[3] <= 1'b1;
		pst[5] <= 2'h1;
		pdst[5] <= 8'h3C;
		pdb[5] <= 1'b1;
		apb(1'b1, 8'h23, 32'hFFFF_F9EF);
		rd(8'h23, 32'h02A5_0925);
		chk({26'h0, link_net[3], link_dir[3]}, 32'h0000_0029);
		apb(1'b1, 8'h45, 32'hFFFF_FFFF);
		rd(8'h45, 32'h013C_0032);
		chk({30'h0, processor_link_net[5]}, 32'h0000_0003);
		$display("status done");
	endtask : t_status
	task automatic t_cfg();
		apb(1'b1, 8'h80, 32'hC000_0000);
		@(posedge clk);
		chk({30'h0, link_en[0], link_wide[0]}, 32'h0000_0003);
		rd(8'h80, 32'hC000_0000);
		grant <= 1'b1;
		rd(8'h80, 32'hC600_0000);
		rx_err[0] <= 1'b1;
		@(posedge clk);
		rx_err[0] <= 1'b0;
		rd(8'h80, 32'hCE00_0000);
		apb(1'b1, 8'h80, 32'hC100_0000);
		rd(8'h80, 32'hCC00_0000);
		chk(credit_request_token_cnt, 1);
		apb(1'b1, 8'h80, 32'hC080_0000);
		rd(8'h80, 32'hC400_0000);
		chk(rxr_cnt, 1);
		grant <= 1'b0;
		apb(1'b1, 8'h80, 32'h0000_0000);
		@(posedge clk);
		chk({30'h0, link_en[0], link_wide[0]}, 32'h0000_0000);
		$display("link setup done");
	endtask : t_cfg
	task automatic t_pace();
		apb(1'b1, 8'h80, 32'h8000_1805);
		grant <= 1'b1;
		go <= 1'b1;
		repeat (40) @(posedge clk);
		chk({20'h0, low_run}, 32'h0000_0004);
		tok_mode <= 1'b1;
		repeat (40) @(posedge clk);
		chk({20'h0, low_run}, 32'h0000_0006);
		go <= 1'b0;
		grant <= 1'b0;
		repeat (3) @(posedge clk);
		chk({31'h0, tx_ready[0]}, 32'h0000_0000);
		$display("pacing done");
	endtask : t_pace
	task automatic t_static();
		for (int k = 0; k < 8; k++) begin
			apb(1'b1, 8'(8'hA0 + k), {1'b1, 26'h3FF_FFFF, 5'(k + 16)});
			rd(8'(8'hA0 + k), {1'b1, 26'h0, 5'(k + 16)});
			chk({26'h0, st_en[k ^ 2], st_ce[k ^ 2]}, 32'h30 + k);
		end
		$display("static done");
	endtask : t_static
	task automatic t_debug();
		apb(1'b1, 8'h10, 32'h0000_0001);
		apb(1'b1, 8'h11, 32'h0000_0002);
		halted <= 2'b01;
		repeat (8) @(posedge clk);
		chk({30'h0, dbg_oe_n, dbg_o}, 32'h0000_0000);
		chk({30'h0, dbg_req}, 32'h0000_0002);
		apb(1'b0, 8'h1F, 32'h0000_0000);
		chk(rdat & 32'h3, 32'h0000_0001);
		halted <= 2'b00;
		apb(1'b1, 8'h1F, 32'h0000_0000);
		ext_n <= 1'b0;
		repeat (8) @(posedge clk);
		chk({30'h0, dbg_req}, 32'h0000_0002);
		apb(1'b0, 8'h1F, 32'h0000_0000);
		chk(rdat & 32'h13, 32'h0000_0010);
		ext_n <= 1'b1;
		apb(1'b1, 8'h11, 32'h0000_0001);
		repeat (8) @(posedge clk);
		apb(1'b1, 8'h1F, 32'h0000_0000);
		halted <= 2'b10;
		repeat (8) @(posedge clk);
		chk({31'h0, dbg_oe_n}, 32'h0000_0000);
		chk({30'h0, dbg_req}, 32'h0000_0000);
		apb(1'b0, 8'h1F, 32'h0000_0000);
		chk(rdat & 32'h3, 32'h0000_0002);
		$display("debug done");
	endtask : t_debug
	initial begin
		rst_n = 1'b0;
		{psel, penable, pwrite, grant, go, tok_mode} = 6'h00;
		ext_n = 1'b1;
		paddr = 10'h000;
		pwdata = 32'h0000_0000;
		node_id = 16'h0000;
		dest_id = 16'h0000;
		halted = 2'b00;
		{lst, pst} = 32'h0000_0000;
		{ldst, pdst} = 128'h0;
		{ljk, ldb, lsb, pjk, pdb, psb, rx_err} = 56'h0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		t_reset();
		t_route();
		t_status();
		t_cfg();
		t_pace();
		t_static();
		t_debug();
		close_out();
	end
endmodule : tb_switch_link_routing_config_regs
